// *** include/nibble_subtract_defines.vh ***
// constants for the nibble subtract unit: register map, fields, opcodes
// assumes a 32-bit AHB-Lite register bus and a 7-bit nibble data memory
`ifndef NIBBLE_SUBTRACT_DEFINES_VH
`define NIBBLE_SUBTRACT_DEFINES_VH

// ****************************************************************
// register byte offsets
// ****************************************************************
`define OFS_CONTROL 12'h000
`define OFS_FLAGS 12'h004
`define OFS_INDEX 12'h008
`define OFS_REG_POINTER 12'h00C
`define OFS_INSTRUCTION 12'h010
`define OFS_MEM_BASE 12'h200
`define MEM_WINDOW_BIT 9

// ****************************************************************
// control register fields
// ****************************************************************
`define CTL_COMPARE_BIT 0
`define CTL_DECIMAL_BIT 1
`define CTL_INDEX_EN_BIT 2
`define CONTROL_RESET 3'h0

// ****************************************************************
// flags register fields
// ****************************************************************
`define FLG_CARRY_BIT 0
`define FLG_ZERO_BIT 1
`define FLAGS_RESET 2'h0

// ****************************************************************
// instruction word layout
// ****************************************************************
`define OPC_HI 15
`define OPC_LO 11
`define ROW_HI 10
`define ROW_LO 8
`define COL_HI 7
`define COL_LO 4
`define LOW_HI 3
`define LOW_LO 0
`define OPC_SUB_MEM_IMM 5'h11
`define OPC_SUB_REG_MEM 5'h01

// ****************************************************************
// misc constants
// ****************************************************************
`define HTRANS_NONSEQ_BIT 1
`define DECIMAL_BORROW_FIX 4'hA
`define NIBBLE_ZERO 4'h0
`define INDEX_RESET 12'h000
`define RPTR_RESET 4'h0
`define INSTR_RESET 16'h0000

`endif

// *** rtl/nibble_subtract_unit.v ***
// nibble subtract unit: register-minus-memory and memory-minus-immediate
// assumes one AHB-Lite master, single word transfers, sys_clk_in at 10 MHz
`timescale 1ns/10ps
`default_nettype none
`include "nibble_subtract_defines.vh"

module nibble_subtract_unit #(
  parameter ADDR_W = 7,
  parameter MEM_DEPTH = 128
) (
  input wire sys_clk_in,
  input wire rst_b_in,
  input wire hsel_in,
  input wire [31:0] haddr_in,
  input wire [1:0] htrans_in,
  input wire hwrite_in,
  input wire [2:0] hsize_in,
  input wire [31:0] hwdata_in,
  input wire hready_in,
  output wire [31:0] hrdata_out,
  output wire hreadyout_out,
  output wire hresp_out,
  output wire carry_borrow_flag_out,
  output wire zero_flag_out,
  output wire busy_out
);

  // ****************************************************************
  // state encoding
  // ****************************************************************
  localparam ST_IDLE = 2'b01;
  localparam ST_EXEC = 2'b10;

  // ****************************************************************
  // storage
  // ****************************************************************
  reg [3:0] data_mem [0:MEM_DEPTH-1];
  reg [1:0] state_ff;
  reg [1:0] nxt_state;
  reg [2:0] control_ff;
  reg [2:0] nxt_control;
  reg carry_ff;
  reg nxt_carry;
  reg zero_ff;
  reg nxt_zero;
  reg [11:0] index_register_ff;
  reg [11:0] nxt_index_register;
  reg [3:0] rptr_low_ff;
  reg [3:0] nxt_rptr_low;
  reg [15:0] instr_ff;
  reg [15:0] nxt_instr;
  reg [31:0] rdata_ff;
  reg [31:0] nxt_rdata;
  reg dp_write_ff;
  reg [11:0] dp_addr_ff;
  reg dp_read_ff;

  // ****************************************************************
  // bus address phase
  // ****************************************************************
  wire addr_phase;
  wire [11:0] a_ofs;
  wire a_is_mem;
  wire [ADDR_W-1:0] a_mem_idx;
  wire d_is_mem;
  wire [ADDR_W-1:0] d_mem_idx;
  wire bus_wr;

  // hsize is always a word here; narrower accesses act on the whole word
  assign addr_phase = hsel_in & htrans_in[`HTRANS_NONSEQ_BIT] & hready_in;
  assign a_ofs = haddr_in[11:0];
  assign a_is_mem = a_ofs[`MEM_WINDOW_BIT];
  assign a_mem_idx = a_ofs[ADDR_W+1:2];
  assign d_is_mem = dp_addr_ff[`MEM_WINDOW_BIT];
  assign d_mem_idx = dp_addr_ff[ADDR_W+1:2];
  assign bus_wr = dp_write_ff;

  // pending data phase; frozen while the execution cycle holds the bus
  always @(posedge sys_clk_in) begin
    if (!rst_b_in) begin
      dp_write_ff <= 1'b0;
      dp_read_ff <= 1'b0;
      dp_addr_ff <= 12'h000;
    end else if (hreadyout_out) begin
      dp_write_ff <= addr_phase & hwrite_in;
      dp_read_ff <= addr_phase & ~hwrite_in;
      dp_addr_ff <= a_ofs;
    end
  end

  // ****************************************************************
  // instruction fields and operand addressing
  // ****************************************************************
  wire [4:0] opcode;
  wire is_mem_imm;
  wire is_reg_mem;
  wire [ADDR_W-1:0] mem_addr;
  wire [ADDR_W-1:0] reg_addr;
  wire compare_only_flag;
  wire decimal_flag;
  wire index_enable_flag;

  assign compare_only_flag = control_ff[`CTL_COMPARE_BIT];
  assign decimal_flag = control_ff[`CTL_DECIMAL_BIT];
  assign index_enable_flag = control_ff[`CTL_INDEX_EN_BIT];
  assign opcode = instr_ff[`OPC_HI:`OPC_LO];
  assign is_mem_imm = (opcode == `OPC_SUB_MEM_IMM);
  assign is_reg_mem = (opcode == `OPC_SUB_REG_MEM);

  operand_address_former #(
    .ADDR_W(ADDR_W)
  ) u_addr (
    .memory_row_field_in(instr_ff[`ROW_HI:`ROW_LO]),
    .memory_column_field_in(instr_ff[`COL_HI:`COL_LO]),
    .reg_field_in(instr_ff[`LOW_HI:`LOW_LO]),
    .index_register_in(index_register_ff),
    .index_enable_flag_in(index_enable_flag),
    .register_pointer_low_in(rptr_low_ff),
    .mem_addr_out(mem_addr),
    .reg_addr_out(reg_addr)
  );

  // ****************************************************************
  // arithmetic
  // ****************************************************************
  wire [3:0] minuend;
  wire [3:0] subtrahend;
  wire [3:0] difference;
  wire borrow;
  wire [ADDR_W-1:0] dest_addr;
  wire exec_valid;
  wire result_write;

  // memory-minus-immediate: memory is the minuend, nibble the subtrahend
  assign minuend = is_mem_imm ? data_mem[mem_addr] : data_mem[reg_addr];
  assign subtrahend = is_mem_imm ? instr_ff[`LOW_HI:`LOW_LO] : data_mem[mem_addr];
  assign dest_addr = is_mem_imm ? mem_addr : reg_addr;
  assign exec_valid = state_ff[1] & (is_mem_imm | is_reg_mem);
  assign result_write = exec_valid & ~compare_only_flag;

  nibble_subtractor u_sub (
    .minuend_in(minuend),
    .subtrahend_in(subtrahend),
    .decimal_in(decimal_flag),
    .result_out(difference),
    .borrow_out(borrow)
  );

  // ****************************************************************
  // sequencing
  // ****************************************************************
  // bus is stalled during execution so bus and datapath never race
  assign hreadyout_out = state_ff[0];
  assign hresp_out = 1'b0;
  assign busy_out = state_ff[1];

  always @* begin
    nxt_state = state_ff;
    case (state_ff)
      ST_IDLE: begin
        // every opcode takes the execution cycle; only two of them act
        if (bus_wr && !d_is_mem && dp_addr_ff == `OFS_INSTRUCTION) begin
          nxt_state = ST_EXEC;
        end
      end
      ST_EXEC: begin
        nxt_state = ST_IDLE;
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
  end

  // ****************************************************************
  // software registers and flags
  // ****************************************************************
  always @* begin
    nxt_control = control_ff;
    nxt_index_register = index_register_ff;
    nxt_rptr_low = rptr_low_ff;
    nxt_instr = instr_ff;
    nxt_carry = carry_ff;
    nxt_zero = zero_ff;
    // bus writes wait for the idle state, so they never race an execution
    if (bus_wr && !d_is_mem && state_ff[0]) begin
      case (dp_addr_ff)
        `OFS_CONTROL: begin
          nxt_control = hwdata_in[2:0];
        end
        `OFS_FLAGS: begin
          // software presets zero before a multi-nibble compare
          nxt_carry = hwdata_in[`FLG_CARRY_BIT];
          nxt_zero = hwdata_in[`FLG_ZERO_BIT];
        end
        `OFS_INDEX: begin
          nxt_index_register = hwdata_in[11:0];
        end
        `OFS_REG_POINTER: begin
          nxt_rptr_low = hwdata_in[3:0];
        end
        `OFS_INSTRUCTION: begin
          nxt_instr = hwdata_in[15:0];
        end
        default: begin
          nxt_instr = instr_ff;
        end
      endcase
    end
    if (exec_valid) begin
      nxt_carry = borrow;
      if (difference != `NIBBLE_ZERO) begin
        nxt_zero = 1'b0;
      end else if (!compare_only_flag) begin
        nxt_zero = 1'b1;
      end else begin
        nxt_zero = zero_ff;
      end
    end
  end

  always @(posedge sys_clk_in) begin
    if (!rst_b_in) begin
      state_ff <= ST_IDLE;
      control_ff <= `CONTROL_RESET;
      carry_ff <= 1'b0;
      zero_ff <= 1'b0;
      index_register_ff <= `INDEX_RESET;
      rptr_low_ff <= `RPTR_RESET;
      instr_ff <= `INSTR_RESET;
    end else begin
      state_ff <= nxt_state;
      control_ff <= nxt_control;
      carry_ff <= nxt_carry;
      zero_ff <= nxt_zero;
      index_register_ff <= nxt_index_register;
      rptr_low_ff <= nxt_rptr_low;
      instr_ff <= nxt_instr;
    end
  end

  assign carry_borrow_flag_out = carry_ff;
  assign zero_flag_out = zero_ff;

  // ****************************************************************
  // data memory
  // ****************************************************************
  // no reset: memory content is undefined until written, like real RAM
  // a result and a bus write never meet in one cycle; the result wins if so
  genvar gi;
  generate
    for (gi = 0; gi < MEM_DEPTH; gi = gi + 1) begin : g_mem
      always @(posedge sys_clk_in) begin
        if (result_write && dest_addr == gi) begin
          data_mem[gi] <= difference;
        end else if (bus_wr && d_is_mem && state_ff[0] && d_mem_idx == gi) begin
          data_mem[gi] <= hwdata_in[3:0];
        end
      end
    end
  endgenerate

  // ****************************************************************
  // read data
  // ****************************************************************
  // a read taken at the edge that starts an execution is answered after it;
  // its word is fetched again at the end of the execution cycle, with the
  // flags and nibble the execution leaves, so software never reads stale data
  wire rd_refresh;
  wire rd_is_mem;
  wire [11:0] rd_ofs;
  wire [ADDR_W-1:0] rd_mem_idx;
  wire [3:0] rd_nibble;
  wire rd_carry;
  wire rd_zero;

  assign rd_refresh = state_ff[1] & dp_read_ff;
  assign rd_is_mem = rd_refresh ? d_is_mem : a_is_mem;
  assign rd_ofs = rd_refresh ? dp_addr_ff : a_ofs;
  assign rd_mem_idx = rd_refresh ? d_mem_idx : a_mem_idx;
  assign rd_nibble = (rd_refresh && result_write && dest_addr == rd_mem_idx) ?
    difference : data_mem[rd_mem_idx];
  assign rd_carry = rd_refresh ? nxt_carry : carry_ff;
  assign rd_zero = rd_refresh ? nxt_zero : zero_ff;

  always @* begin
    nxt_rdata = 32'h00000000;
    if (rd_is_mem) begin
      nxt_rdata = {28'h0000000, rd_nibble};
    end else begin
      case (rd_ofs)
        `OFS_CONTROL: begin
          nxt_rdata = {29'h00000000, control_ff};
        end
        `OFS_FLAGS: begin
          nxt_rdata = {30'h00000000, rd_zero, rd_carry};
        end
        `OFS_INDEX: begin
          nxt_rdata = {20'h00000, index_register_ff};
        end
        `OFS_REG_POINTER: begin
          nxt_rdata = {28'h0000000, rptr_low_ff};
        end
        `OFS_INSTRUCTION: begin
          nxt_rdata = {16'h0000, instr_ff};
        end
        default: begin
          nxt_rdata = 32'h00000000;
        end
      endcase
    end
  end

  always @(posedge sys_clk_in) begin
    if (!rst_b_in) begin
      rdata_ff <= 32'h00000000;
    // hrdata changes only when a read is taken or refreshed
    end else if ((addr_phase && !hwrite_in && hreadyout_out) || rd_refresh) begin
      rdata_ff <= nxt_rdata;
    end
  end

  assign hrdata_out = rdata_ff;

endmodule // nibble_subtract_unit

`default_nettype wire

// *** rtl/nibble_subtractor.v ***
// one-nibble subtractor, binary or decimal, with borrow out
// assumes operands are single nibbles; decimal operands are valid digits
`timescale 1ns/10ps
`default_nettype none

module nibble_subtractor (
  input wire [3:0] minuend_in,
  input wire [3:0] subtrahend_in,
  input wire decimal_in,
  output wire [3:0] result_out,
  output wire borrow_out
);
  wire [4:0] raw_diff;
  wire [3:0] fixed_diff;

  assign raw_diff = {1'b0, minuend_in} - {1'b0, subtrahend_in};
  assign borrow_out = raw_diff[4];
  // binary simply wraps modulo sixteen
  assign fixed_diff = raw_diff[3:0] + `DECIMAL_BORROW_FIX;
  assign result_out = (decimal_in && borrow_out) ? fixed_diff : raw_diff[3:0];
endmodule // nibble_subtractor

`default_nettype wire

// *** rtl/operand_address_former.v ***
// forms the memory operand address and the general register address
// assumes a flat 7-bit nibble memory; bank bits of the index are dropped
`timescale 1ns/10ps
`default_nettype none

module operand_address_former #(
  parameter ADDR_W = 7
) (
  input wire [2:0] memory_row_field_in,
  input wire [3:0] memory_column_field_in,
  input wire [3:0] reg_field_in,
  input wire [11:0] index_register_in,
  input wire index_enable_flag_in,
  input wire [3:0] register_pointer_low_in,
  output wire [ADDR_W-1:0] mem_addr_out,
  output wire [ADDR_W-1:0] reg_addr_out
);
  wire [ADDR_W-1:0] plain_addr;

  assign plain_addr = {memory_row_field_in, memory_column_field_in};
  // OR, not add: carries never ripple into the row bits
  assign mem_addr_out = index_enable_flag_in ?
    (plain_addr | index_register_in[ADDR_W-1:0]) : plain_addr;
  // register operand ignores the index; row comes from the pointer
  assign reg_addr_out = {register_pointer_low_in[3:1], reg_field_in};
endmodule // operand_address_former

`default_nettype wire

// *** sim/nibble_subtract_monitor.sv ***
// bus and flag timing checker for the nibble subtract unit
// assumes hready_in is the unit's own hreadyout_out
`timescale 1ns/10ps
`default_nettype none
`include "nibble_subtract_defines.vh"

module nibble_subtract_monitor (
  input wire logic sys_clk_in,
  input wire logic rst_b_in,
  input wire logic hsel_in,
  input wire logic [31:0] haddr_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic [2:0] hsize_in,
  input wire logic [31:0] hwdata_in,
  input wire logic hready_in,
  input wire logic [31:0] hrdata_out,
  input wire logic hreadyout_out,
  input wire logic hresp_out,
  input wire logic carry_borrow_flag_out,
  input wire logic zero_flag_out,
  input wire logic busy_out
);
  // ****
  // taken requests
  // ****
  logic req_ok;
  logic instr_req;
  logic flag_wr;
  logic rd_req;
  assign req_ok = hsel_in & htrans_in[1] & hready_in;
  assign instr_req = req_ok & hwrite_in & (haddr_in[11:0] == `OFS_INSTRUCTION);
  assign flag_wr = req_ok & hwrite_in & (haddr_in[11:0] == `OFS_FLAGS);
  assign rd_req = req_ok & ~hwrite_in;

  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!rst_b_in);

  sequence instr_taken;
    instr_req;
  endsequence
  sequence exec_cycle;
    (busy_out && !hreadyout_out) ##1 (!busy_out && hreadyout_out);
  endsequence

  exec_start_a: assert property (instr_taken |-> ##2 exec_cycle)
    else $error("instruction write not followed by one execution cycle");
  busy_cause_a: assert property ($rose(busy_out) |-> $past(instr_req, 2))
    else $error("execution without an instruction write");
  stall_busy_a: assert property (busy_out != hreadyout_out)
    else $error("stall and busy disagree");
  stall_once_a: assert property (!hreadyout_out |=> hreadyout_out)
    else $error("stall longer than one cycle");
  resp_okay_a: assert property (hresp_out == 1'b0)
    else $error("error response seen");
  flags_cause_a: assert property (($changed(carry_borrow_flag_out) || $changed(zero_flag_out))
    |-> ($past(busy_out) || $past(flag_wr, 2)))
    else $error("flags changed with no execution or write");
  flags_hold_a: assert property (busy_out |->
    $stable({carry_borrow_flag_out, zero_flag_out}))
    else $error("flags moved before execution");
  rdata_cause_a: assert property ($changed(hrdata_out)
    |-> ($past(rd_req) || ($past(busy_out) && $past(rd_req, 2))))
    else $error("read data changed without a read");
endmodule // nibble_subtract_monitor

bind nibble_subtract_unit nibble_subtract_monitor u_nibble_subtract_monitor (.sys_clk_in,
  .rst_b_in, .hsel_in, .haddr_in, .htrans_in, .hwrite_in, .hsize_in, .hwdata_in, .hready_in,
  .hrdata_out, .hreadyout_out, .hresp_out, .carry_borrow_flag_out, .zero_flag_out, .busy_out);
`default_nettype wire

// *** sim/test_nibble_subtract_unit.sv ***
// self-checking bench for the nibble subtract unit over its register bus
// assumes the unit answers its own bus; data memory is written before use
`timescale 1ns/10ps
`default_nettype none
`include "nibble_subtract_defines.vh"

module test_nibble_subtract_unit;
  logic sys_clk_in = 1'b0;
  logic rst_b_in = 1'b0;
  logic hsel_in = 1'b0;
  logic [31:0] haddr_in = 32'h00000000;
  logic [1:0] htrans_in = 2'h0;
  logic hwrite_in = 1'b0;
  logic [31:0] hwdata_in = 32'h00000000;
  wire [31:0] hrdata_out;
  wire hreadyout_out;
  wire hresp_out;
  wire carry_borrow_flag_out;
  wire zero_flag_out;
  wire busy_out;
  int bad_count = 0;
  int n_compared = 0;
  logic [31:0] rv;

  always #50 sys_clk_in = ~sys_clk_in;

  nibble_subtract_unit u_nibble_subtract_unit (.sys_clk_in, .rst_b_in, .hsel_in, .haddr_in,
    .htrans_in, .hwrite_in, .hsize_in(3'h2), .hwdata_in, .hready_in(hreadyout_out),
    .hrdata_out, .hreadyout_out, .hresp_out, .carry_borrow_flag_out, .zero_flag_out,
    .busy_out);

  // ****
  // bus and compare tasks
  // ****
  task automatic complete_run;
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // checked at the falling edge so the value is the one the next rising edge samples
  task automatic wait_ready;
    int n;
    n = 0;
    @(negedge sys_clk_in);
    while (hreadyout_out !== 1'b1) begin
      n++;
      if (n > 20) begin
        bad_count++;
        $display("ERROR %0t bus hang", $time);
        complete_run();
      end
      @(negedge sys_clk_in);
    end
  endtask

  task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    hsel_in <= 1'b1;
    haddr_in <= {20'h00000, a};
    htrans_in <= 2'h2;
    hwrite_in <= wr;
    wait_ready();
    @(posedge sys_clk_in);
    htrans_in <= 2'h0;
    hsel_in <= 1'b0;
    hwdata_in <= wd;
    wait_ready();
    @(posedge sys_clk_in);
    rv = hrdata_out;
  endtask

  function automatic logic [11:0] ma(input logic [6:0] n);
    return `OFS_MEM_BASE | {3'h0, n, 2'h0};
  endfunction

  function automatic logic [15:0] ins(input logic [4:0] op, input logic [6:0] m,
    input logic [3:0] v);
    return {op, m, v};
  endfunction

  task automatic mw(input logic [6:0] n, input logic [3:0] d);
    bus(1'b1, ma(n), {28'h0000000, d});
  endtask

  task automatic mchk(input logic [6:0] n, input logic [3:0] d);
    bus(1'b0, ma(n), 32'h00000000);
    chk(rv, {28'h0000000, d});
  endtask

  // control, then instruction, then flags by register and by port as {zero, carry}
  task automatic ex(input logic [2:0] ctl, input logic [15:0] i, input logic [1:0] zc);
    bus(1'b1, `OFS_CONTROL, {29'h00000000, ctl});
    bus(1'b1, `OFS_INSTRUCTION, {16'h0000, i});
    bus(1'b0, `OFS_FLAGS, 32'h00000000);
    chk(rv, {30'h00000000, zc});
    chk({30'h00000000, zero_flag_out, carry_borrow_flag_out}, {30'h00000000, zc});
  endtask

  // ****
  // scenarios
  // ****
  task automatic t_imm;
    mw(7'h2F, 4'h7);
    ex(3'h0, ins(5'h11, 7'h2F, 4'h5), 2'h0);
    mchk(7'h2F, 4'h2);
    ex(3'h0, ins(5'h11, 7'h2F, 4'h5), 2'h1);
    mchk(7'h2F, 4'hD);
    mw(7'h2F, 4'h5);
    ex(3'h0, ins(5'h11, 7'h2F, 4'h5), 2'h2);
    mchk(7'h2F, 4'h0);
    $display("test immediate done");
  endtask

  task automatic t_cmp;
    mw(7'h2F, 4'h4);
    bus(1'b1, `OFS_FLAGS, 32'h00000003);
    ex(3'h1, ins(5'h11, 7'h2F, 4'h4), 2'h2);
    mchk(7'h2F, 4'h4);
    bus(1'b1, `OFS_FLAGS, 32'h00000000);
    ex(3'h1, ins(5'h11, 7'h2F, 4'h4), 2'h0);
    bus(1'b1, `OFS_FLAGS, 32'h00000002);
    ex(3'h1, ins(5'h11, 7'h2F, 4'h5), 2'h1);
    mchk(7'h2F, 4'h4);
    $display("test compare done");
  endtask

  task automatic t_dec;
    mw(7'h2F, 4'h2);
    ex(3'h2, ins(5'h11, 7'h2F, 4'h5), 2'h1);
    mchk(7'h2F, 4'h7);
    mw(7'h2F, 4'h9);
    ex(3'h2, ins(5'h11, 7'h2F, 4'h3), 2'h0);
    mchk(7'h2F, 4'h6);
    $display("test decimal done");
  endtask

  task automatic t_reg;
    bus(1'b1, `OFS_REG_POINTER, 32'h00000004);
    mw(7'h03, 4'h1);
    mw(7'h23, 4'h9);
    mw(7'h2F, 4'h4);
    ex(3'h0, ins(5'h01, 7'h2F, 4'h3), 2'h0);
    mchk(7'h23, 4'h5);
    mchk(7'h03, 4'h1);
    bus(1'b1, `OFS_REG_POINTER, 32'h00000000);
    bus(1'b1, `OFS_INDEX, 32'h00000040);
    mw(7'h6F, 4'h2);
    mw(7'h03, 4'h8);
    mw(7'h43, 4'hF);
    ex(3'h4, ins(5'h01, 7'h2F, 4'h3), 2'h0);
    mchk(7'h03, 4'h6);
    mchk(7'h43, 4'hF);
    ex(3'h1, ins(5'h01, 7'h2F, 4'h3), 2'h0);
    mchk(7'h03, 4'h6);
    $display("test register form done");
  endtask

  task automatic t_idx;
    bus(1'b1, `OFS_INDEX, 32'h00000010);
    mw(7'h3F, 4'h8);
    mw(7'h2F, 4'hA);
    ex(3'h4, ins(5'h11, 7'h2F, 4'h5), 2'h0);
    mchk(7'h3F, 4'h3);
    bus(1'b1, `OFS_INDEX, 32'h00000020);
    mw(7'h4F, 4'h9);
    ex(3'h4, ins(5'h11, 7'h2F, 4'h1), 2'h0);
    mchk(7'h2F, 4'h9);
    mchk(7'h4F, 4'h9);
    bus(1'b1, `OFS_FLAGS, 32'h00000003);
    mw(7'h2F, 4'h6);
    ex(3'h0, ins(5'h13, 7'h2F, 4'h1), 2'h3);
    mchk(7'h2F, 4'h6);
    $display("test index and opcode done");
  endtask

  initial begin
    repeat (2) @(posedge sys_clk_in);
    rst_b_in <= 1'b1;
    t_imm();
    t_cmp();
    t_dec();
    t_reg();
    t_idx();
    complete_run();
  end
endmodule // test_nibble_subtract_unit
`default_nettype wire
